// *** bsb_pkg.sv ***
// Shared constants and carrier types of the bipolar stepper bridge control.
// Assumes one 25 MHz system clock and a 32-bit Avalon-MM register port.
package bsb_pkg;

	// ------------------------------------------------------------
	// Sizes and clock
	// ------------------------------------------------------------
	localparam int COILS      = 2;
	localparam int CLK_HZ     = 25000000;
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 5;
	localparam int EVT_W      = 4;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 5'h10;

	// Control register fields and reset values
	localparam int CTRL_DRIVE_EN = 0;
	localparam logic CTRL_DRIVE_EN_RESET = 1'h1;
	localparam logic [EVT_W-1:0] IRQ_EN_RESET = 4'h0;

	// Status register fields
	localparam int ST_STANDBY   = 0;
	localparam int ST_POR_OK    = 1;
	localparam int ST_THERMAL   = 2;
	localparam int ST_OC_BASE   = 3;
	localparam int ST_CHOP_BASE = 5;

	// Event bits, shared by status, clear and enable registers
	localparam int EVT_THERMAL = 0;
	localparam int EVT_OC_BASE = 1;
	localparam int EVT_WAKE    = 3;

	// ------------------------------------------------------------
	// Synchroniser bit positions of the pin inputs
	// ------------------------------------------------------------
	localparam int PIN_SEL_BASE  = 0;
	localparam int PIN_DIR_BASE  = 4;
	localparam int PIN_SENSE_BASE = 6;
	localparam int PIN_OC_BASE   = 8;
	localparam int PIN_STBY_N    = 10;
	localparam int PIN_THERMAL   = 11;
	localparam int PIN_VM_OK     = 12;
	localparam int PIN_VCC_OK    = 13;
	localparam int PIN_OSC       = 14;
	localparam int PIN_W         = 15;

	// ------------------------------------------------------------
	// Current targets in percent, signed
	// ------------------------------------------------------------
	localparam logic signed [7:0] PCT_FULL = 8'sh64;
	localparam logic signed [7:0] PCT_MID  = 8'sh47;
	localparam logic signed [7:0] PCT_LOW  = 8'sh26;
	localparam logic signed [7:0] PCT_OFF  = 8'sh00;

	typedef enum logic [1:0] {
		LVL_OFF,
		LVL_LOW,
		LVL_MID,
		LVL_FULL
	} bsb_level_type;

	// Bridge drive of one coil
	typedef struct packed {
		logic enable;
		logic posHigh;
		logic negHigh;
	} bsb_drive_type;

endpackage

// *** bsb_coil.sv ***
// One coil: level decode, polarity and constant-current chopper gate.
// Assumes its inputs are already synchronous to clk_sys.
`timescale 1ns/1ns
module bsb_coil (
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic [1:0]         levelSel,
	input  wire logic               dir,
	input  wire logic               run,
	input  wire logic               periodStart,
	input  wire logic               senseReached,
	output bsb_pkg::bsb_drive_type  drive,
	output logic signed [7:0]       targetPct,
	output logic                    chopOn
);
	import bsb_pkg::*;

	typedef struct packed {
		logic              chopOn;
		bsb_drive_type     drive;
		logic signed [7:0] targetPct;
	} bsb_coil_state_type;

	bsb_coil_state_type st;
	bsb_coil_state_type next_st;
	bsb_level_type      level;
	logic signed [7:0]  magnitude;

	// ------------------------------------------------------------
	// Level decode
	// ------------------------------------------------------------
	always_comb begin
		case (levelSel)
			2'h3: level = LVL_FULL;
			2'h2: level = LVL_MID;
			2'h1: level = LVL_LOW;
			default: level = LVL_OFF;
		endcase
		case (level)
			LVL_FULL: magnitude = PCT_FULL;
			LVL_MID: magnitude = PCT_MID;
			LVL_LOW: magnitude = PCT_LOW;
			default: magnitude = PCT_OFF;
		endcase
	end

	// ------------------------------------------------------------
	// Chopper and bridge
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (!run || level == LVL_OFF) begin
			next_st.chopOn = 1'h0;
		end else if (periodStart) begin
			next_st.chopOn = 1'h1;
		end else if (senseReached) begin
			next_st.chopOn = 1'h0;
		end
		next_st.drive.enable  = next_st.chopOn;
		next_st.drive.posHigh = next_st.chopOn & dir;
		next_st.drive.negHigh = next_st.chopOn & ~dir;
		if (!run || level == LVL_OFF) begin
			next_st.targetPct = PCT_OFF;
		end else if (dir) begin
			next_st.targetPct = magnitude;
		end else begin
			next_st.targetPct = -magnitude;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign drive     = st.drive;
	assign targetPct = st.targetPct;
	assign chopOn    = st.chopOn;

endmodule

// *** bsb_top.sv ***
// Control logic of a two-coil bipolar stepper bridge driver.
// Assumes pin inputs are asynchronous to clk_sys and the register
// port is an Avalon-MM slave on clk_sys.
`timescale 1ns/1ns
module bsb_top (
	input  wire logic                       clk_sys,
	input  wire logic                       rstn,
	// Step controller pins
	input  wire logic                       level_sel_coil1_bit1,
	input  wire logic                       level_sel_coil1_bit2,
	input  wire logic                       level_sel_coil2_bit1,
	input  wire logic                       level_sel_coil2_bit2,
	input  wire logic                       dirCoil1,
	input  wire logic                       dirCoil2,
	input  wire logic                       standbyN,
	// Oscillator, protection and sense inputs
	input  wire logic                       chop_osc_pin,
	input  wire logic                       thermal_trip,
	input  wire logic [bsb_pkg::COILS-1:0]  overcurrent_trip,
	input  wire logic [bsb_pkg::COILS-1:0]  senseReached,
	input  wire logic                       motor_supply_monitor,
	input  wire logic                       logic_supply_monitor,
	// Bridge drive and current targets
	output bsb_pkg::bsb_drive_type          coilDrive1,
	output bsb_pkg::bsb_drive_type          coilDrive2,
	output logic signed [7:0]               targetPct1,
	output logic signed [7:0]               targetPct2,
	// Avalon-MM slave
	input  wire logic [bsb_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [bsb_pkg::DATA_W-1:0] avs_writedata,
	output logic [bsb_pkg::DATA_W-1:0]      avs_readdata,
	output logic                            avs_waitrequest,
	// Interrupt
	output logic                            irq
);
	import bsb_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0]  sync1;
		logic [PIN_W-1:0]  sync2;
		logic              oscPrev;
		logic              standbyPrev;
		logic              thermalLatch;
		logic [COILS-1:0]  ocLatch;
		logic              driveEn;
		logic [EVT_W-1:0]  irqStat;
		logic [EVT_W-1:0]  irqEn;
		logic              ack;
		logic [DATA_W-1:0] readData;
	} bsb_state_type;

	bsb_state_type       st;
	bsb_state_type       next_st;
	logic [PIN_W-1:0]    pins;
	logic                standbyActive;
	logic                porOk;
	logic                running;
	logic                periodStart;
	logic [COILS-1:0]    coilRun;
	logic [COILS-1:0]    chopOn;
	logic [EVT_W-1:0]    events;
	logic [EVT_W-1:0]    clrMask;
	logic                request;
	logic                accept;
	logic [DATA_W-1:0]   statusWord;
	logic [DATA_W-1:0]   readMux;
	bsb_drive_type       drive [COILS];
	logic signed [7:0]   target [COILS];

	// ------------------------------------------------------------
	// Pin gathering
	// ------------------------------------------------------------
	always_comb begin
		pins = '0;
		pins[PIN_SEL_BASE]     = level_sel_coil1_bit2;
		pins[PIN_SEL_BASE + 1] = level_sel_coil1_bit1;
		pins[PIN_SEL_BASE + 2] = level_sel_coil2_bit2;
		pins[PIN_SEL_BASE + 3] = level_sel_coil2_bit1;
		pins[PIN_DIR_BASE]     = dirCoil1;
		pins[PIN_DIR_BASE + 1] = dirCoil2;
		pins[PIN_SENSE_BASE +: COILS] = senseReached;
		pins[PIN_OC_BASE +: COILS]    = overcurrent_trip;
		pins[PIN_STBY_N]  = standbyN;
		pins[PIN_THERMAL] = thermal_trip;
		pins[PIN_VM_OK]   = motor_supply_monitor;
		pins[PIN_VCC_OK]  = logic_supply_monitor;
		pins[PIN_OSC]     = chop_osc_pin;
	end

	// ------------------------------------------------------------
	// Operating state
	// ------------------------------------------------------------
	// Everything below reads only the second synchroniser stage
	assign standbyActive = ~st.sync2[PIN_STBY_N];
	assign porOk = st.sync2[PIN_VM_OK] & st.sync2[PIN_VCC_OK];
	assign running = ~standbyActive & porOk & st.driveEn;

	// Oscillator is held stopped in standby
	assign periodStart = st.sync2[PIN_OSC] & ~st.oscPrev
		& ~standbyActive;

	genvar c;
	generate
		for (c = 0; c < COILS; c++) begin : gCoil
			assign coilRun[c] = running & ~st.thermalLatch
				& ~st.ocLatch[c];

			bsb_coil uCoil (
				.clk_sys      (clk_sys),
				.rstn         (rstn),
				.levelSel     (st.sync2[PIN_SEL_BASE + 2*c +: 2]),
				.dir          (st.sync2[PIN_DIR_BASE + c]),
				.run          (coilRun[c]),
				.periodStart  (periodStart),
				.senseReached (st.sync2[PIN_SENSE_BASE + c]),
				.drive        (drive[c]),
				.targetPct    (target[c]),
				.chopOn       (chopOn[c])
			);
		end
	endgenerate

	assign coilDrive1 = drive[0];
	assign coilDrive2 = drive[1];
	assign targetPct1 = target[0];
	assign targetPct2 = target[1];

	// ------------------------------------------------------------
	// Protection and wake events
	// ------------------------------------------------------------
	always_comb begin
		events = '0;
		events[EVT_THERMAL] = st.sync2[PIN_THERMAL] & ~st.thermalLatch;
		events[EVT_OC_BASE +: COILS] = st.sync2[PIN_OC_BASE +: COILS]
			& ~st.ocLatch;
		events[EVT_WAKE] = st.standbyPrev & ~standbyActive;
	end

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	// One wait state: the answer is ready one cycle after the request
	assign request = avs_read | avs_write;
	assign accept = request & st.ack;
	assign avs_waitrequest = request & ~st.ack;

	always_comb begin
		statusWord = '0;
		statusWord[ST_STANDBY] = standbyActive;
		statusWord[ST_POR_OK]  = porOk;
		statusWord[ST_THERMAL] = st.thermalLatch;
		statusWord[ST_OC_BASE +: COILS]   = st.ocLatch;
		statusWord[ST_CHOP_BASE +: COILS] = chopOn;
	end

	always_comb begin
		readMux = '0;
		case (avs_address)
			REG_CTRL: readMux[CTRL_DRIVE_EN] = st.driveEn;
			REG_STATUS: readMux = statusWord;
			REG_IRQ_STAT: readMux[EVT_W-1:0] = st.irqStat;
			REG_IRQ_EN: readMux[EVT_W-1:0] = st.irqEn;
			default: readMux = '0;
		endcase
	end

	always_comb begin
		clrMask = '0;
		if (accept && avs_write && avs_address == REG_IRQ_CLR) begin
			clrMask = avs_writedata[EVT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;
		next_st.oscPrev = st.sync2[PIN_OSC];
		next_st.standbyPrev = standbyActive;

		// Trips win over the standby clear; standby low clears latches
		next_st.thermalLatch = st.sync2[PIN_THERMAL]
			| (st.thermalLatch & ~standbyActive);
		next_st.ocLatch = st.sync2[PIN_OC_BASE +: COILS]
			| (st.ocLatch & {COILS{~standbyActive}});

		// Sticky events, set wins over clear
		next_st.irqStat = (st.irqStat & ~clrMask) | events;

		next_st.ack = request & ~st.ack;
		if (request && !st.ack) begin
			next_st.readData = avs_read ? readMux : '0;
		end

		if (accept && avs_write) begin
			case (avs_address)
				REG_CTRL: next_st.driveEn = avs_writedata[CTRL_DRIVE_EN];
				REG_IRQ_EN: next_st.irqEn = avs_writedata[EVT_W-1:0];
				default: next_st.driveEn = st.driveEn;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.driveEn <= CTRL_DRIVE_EN_RESET;
			st.irqEn <= IRQ_EN_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata = st.readData;
	assign irq = |(st.irqStat & st.irqEn);

endmodule

// *** bsb_top_chk.sv ***
// Port assertions for bsb_top.
// Assumes pins reach the outputs within four clock edges.
`timescale 1ns/1ns
module bsb_chk (
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic	level_sel_coil1_bit1,
	input wire logic	level_sel_coil1_bit2,
	input wire logic	dirCoil1,
	input wire logic	dirCoil2,
	input wire logic	standbyN,
	input wire logic	thermal_trip,
	input wire logic [bsb_pkg::COILS-1:0]	overcurrent_trip,
	input wire logic	motor_supply_monitor,
	input wire logic	logic_supply_monitor,
	input wire bsb_pkg::bsb_drive_type	coilDrive1,
	input wire bsb_pkg::bsb_drive_type	coilDrive2,
	input wire logic signed [7:0]	targetPct1
);
	import bsb_pkg::*;
	wire logic off1 = !coilDrive1.enable;
	wire logic off2 = !coilDrive2.enable;
	wire logic sel0 = !level_sel_coil1_bit1 && !level_sel_coil1_bit2;
	wire logic supOk = motor_supply_monitor && logic_supply_monitor;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_standby_off: assert property ((!standbyN)[*5] |-> off1 && off2)
		else $error("drive on in standby");
	a_supply_off: assert property ((!supOk)[*5] |-> off1 && off2)
		else $error("drive on without supplies");
	a_thermal_off: assert property (thermal_trip[*5] |-> off1 && off2)
		else $error("drive on while hot");
	a_oc_local: assert property ((overcurrent_trip[1])[*5] |-> off2)
		else $error("coil two on in overcurrent");
	a_level_zero: assert property (sel0[*5] |-> off1 && targetPct1 == 0)
		else $error("coil one on with level zero");
	a_dir_high: assert property ((dirCoil1[*5] ##0 !off1) |->
		coilDrive1.posHigh && !coilDrive1.negHigh)
		else $error("coil one polarity wrong");
	a_dir_low: assert property (((!dirCoil2)[*5] ##0 !off2) |->
		coilDrive2.negHigh && !coilDrive2.posHigh)
		else $error("coil two polarity wrong");
	a_sign_neg: assert property (((!dirCoil1)[*5] ##0 targetPct1 != 0)
		|-> targetPct1 < 0)
		else $error("target sign wrong");
endmodule
bind bsb_top bsb_chk chk_u (.clk_sys, .rstn, .level_sel_coil1_bit1,
	.level_sel_coil1_bit2, .dirCoil1, .dirCoil2, .standbyN, .thermal_trip,
	.overcurrent_trip, .motor_supply_monitor, .logic_supply_monitor,
	.coilDrive1, .coilDrive2, .targetPct1);

// *** bsb_ctl_model.sv ***
// Step controller, oscillator and sense comparator model at the pins.
// Assumes the bench clock; sense answers lag plus one cycles after drive on.
`timescale 1ns/1ns
module bsb_ctl (
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic	vmOk,
	input wire logic [1:0]	code1,
	input wire logic [1:0]	code2,
	input wire logic [1:0]	dirIn,
	input wire logic	oscRun,
	input wire logic [3:0]	lag,
	input wire logic [1:0]	en,
	output logic [1:0]	sel1,
	output logic [1:0]	sel2,
	output logic [1:0]	dirs,
	output logic	osc,
	output logic [1:0]	sense
);
	logic [3:0] cnt;
	logic [3:0] age [2];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{sel1, sel2, dirs, osc, cnt, sense} <= '0;
			age <= '{default: '0};
		end else begin
			// Steps only once the motor supply is up
			if (vmOk) begin
				sel1 <= code1;
				sel2 <= code2;
				dirs <= dirIn;
			end
			// Oscillator stands still when stopped
			cnt <= oscRun ? cnt + 4'h1 : 4'h0;
			osc <= oscRun && cnt[3];
			for (int i = 0; i < 2; i++) begin
				age[i] <= en[i] ? age[i] + 4'h1 : 4'h0;
				sense[i] <= en[i] && age[i] >= lag;
			end
		end
	end
endmodule

// *** bsb_top_tb.sv ***
// Self-checking bench for bsb_top with the step controller model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
	end end
module bsb_top_tb;
	import bsb_pkg::*;
	logic clk_sys = 0, rstn = 0, standbyN = 1, thermal = 0, vm = 1, vcc = 1;
	logic oscRun = 1, rd = 0, wr = 0, osc, irq, wreq;
	logic [1:0] code1 = 0, code2 = 0, dirIn = 0, oc = 0;
	logic [1:0] sel1, sel2, dirs, sense;
	logic [3:0] lag = 4'h4;
	logic [4:0] adr = 0;
	logic [31:0] wdat = 0, rdat, q;
	bsb_drive_type d1, d2;
	logic signed [7:0] t1, t2, e;
	int mismatches = 0, checks_done = 0, k;
	logic signed [7:0] pct [4] = '{PCT_OFF, PCT_LOW, PCT_MID, PCT_FULL};
	bsb_ctl ctl_u (.clk_sys, .rstn, .vmOk(vm), .code1, .code2, .dirIn,
		.oscRun, .lag, .en({d2.enable, d1.enable}), .sel1, .sel2, .dirs,
		.osc, .sense);
	bsb_top dut_u (.clk_sys, .rstn, .level_sel_coil1_bit1(sel1[1]),
		.level_sel_coil1_bit2(sel1[0]), .level_sel_coil2_bit1(sel2[1]),
		.level_sel_coil2_bit2(sel2[0]), .dirCoil1(dirs[0]),
		.dirCoil2(dirs[1]), .standbyN, .chop_osc_pin(osc),
		.thermal_trip(thermal), .overcurrent_trip(oc), .senseReached(sense),
		.motor_supply_monitor(vm), .logic_supply_monitor(vcc),
		.coilDrive1(d1), .coilDrive2(d2), .targetPct1(t1), .targetPct2(t2),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.irq);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo;
		mismatches++;
		give_verdict();
	endtask
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int i;
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (wreq !== 1'b0 && i < 20);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20)
			tmo();
		@(posedge clk_sys);
	endtask
	task automatic waitEn(input int c);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge clk_sys);
			if ((c ? d2.enable : d1.enable) === 1'b1)
				break;
		end
		if (i == 60)
			tmo();
	endtask
	task automatic onCount(input int n, input logic [1:0] m);
		k = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if ((m & {d2.enable, d1.enable}) !== 2'h0)
				k++;
		end
	endtask
	task automatic sc_decode;
		for (int d = 0; d < 2; d++) for (int c = 0; c < 4; c++) begin
			code1 <= c[1:0];
			code2 <= c[1:0];
			dirIn <= {d[0], d[0]};
			cyc(8);
			e = d ? pct[c] : -pct[c];
			`CHK("tgt1", e, t1)
			`CHK("tgt2", e, t2)
			if (c == 0) begin
				onCount(20, 2'h3);
				`CHK("off", 0, k)
			end else begin
				waitEn(0);
				`CHK("pos", d[0], d1.posHigh)
				`CHK("neg", !d[0], d1.negHigh)
			end
		end
	endtask
	task automatic sc_regs;
		bus(0, REG_CTRL, 0);
		`CHK("ctrl", 32'h1, q)
		bus(0, REG_IRQ_EN, 0);
		`CHK("irqen", 32'h0, q)
		bus(0, 5'h14, 0);
		`CHK("unmapped", 32'h0, q)
		bus(1, REG_CTRL, 0);
		onCount(40, 2'h3);
		`CHK("drive en", 0, k)
		bus(1, REG_CTRL, 1);
	endtask
	task automatic sc_chop;
		int i;
		for (int j = 0; j < 2; j++) begin
			lag <= j ? 4'h6 : 4'h1;
			cyc(20);
			waitEn(0);
			for (i = 0; i < 20 && sense[0] !== 1'b1; i++)
				@(posedge clk_sys);
			if (i == 20)
				tmo();
			cyc(3);
			`CHK("chop off", 1'b0, d1.enable)
		end
		oscRun <= 1'b0;
		cyc(20);
		onCount(40, 2'h3);
		`CHK("osc still", 0, k)
		oscRun <= 1'b1;
	endtask
	task automatic sc_thermal;
		thermal <= 1'b1;
		cyc(6);
		thermal <= 1'b0;
		onCount(40, 2'h3);
		`CHK("tsd hold", 0, k)
		`CHK("irq masked", 1'b0, irq)
		bus(0, REG_STATUS, 0);
		`CHK("tsd latch", 1'b1, q[ST_THERMAL])
		bus(1, REG_IRQ_EN, 1);
		`CHK("irq", 1'b1, irq)
		bus(0, REG_IRQ_STAT, 0);
		`CHK("istat", 1'b1, q[EVT_THERMAL])
		bus(1, REG_IRQ_CLR, 1);
		`CHK("irq clr", 1'b0, irq)
		standbyN <= 1'b0;
		cyc(6);
		bus(0, REG_STATUS, 0);
		`CHK("stby", 1'b1, q[ST_STANDBY])
		onCount(20, 2'h3);
		`CHK("stby off", 0, k)
		standbyN <= 1'b1;
		waitEn(0);
		`CHK("resume", 1'b1, d1.enable)
	endtask
	task automatic sc_oc;
		oc <= 2'h2;
		cyc(6);
		oc <= 2'h0;
		onCount(40, 2'h2);
		`CHK("oc2 off", 0, k)
		onCount(40, 2'h1);
		`CHK("oc1 runs", 1'b1, k > 0)
		standbyN <= 1'b0;
		cyc(6);
		standbyN <= 1'b1;
		waitEn(1);
		`CHK("oc resume", 1'b1, d2.enable)
	endtask
	task automatic sc_supply;
		for (int i = 0; i < 2; i++) begin
			{vm, vcc} <= i ? 2'h2 : 2'h1;
			cyc(6);
			onCount(40, 2'h3);
			`CHK("supply off", 0, k)
		end
		{vm, vcc} <= 2'h3;
		waitEn(1);
	endtask
	initial begin
		cyc(12);
		rstn <= 1'b1;
		cyc(2);
		sc_decode();
		sc_regs();
		sc_chop();
		sc_thermal();
		sc_oc();
		sc_supply();
		give_verdict();
	end
endmodule
